//--- pkg/plc_tcs_pkg.sv
package plc_tcs_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int          NUM_ELEM        = 64;
    localparam int          ELEM_IDX_W      = 6;
    localparam int          VALUE_W         = 14;
    localparam logic [13:0] VALUE_MAX       = 14'h270F;
    localparam int          POOL_BITS       = 77;
    localparam int          POOL_IDX_W      = 7;
    localparam logic [6:0]  POOL_LAST       = 7'h4C;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_FREQ_KHZ    = 20000;
    localparam int          CENTI_TIME_MS   = 10;
    localparam int          CENTI_CYCLES    = CENTI_TIME_MS * CLK_FREQ_KHZ;
    localparam int          DECI_PER_CENTI  = 10;
    localparam int          DIV_W           = 18;
    localparam logic [3:0]  DECI_LAST       = 4'h9;

    // ----------------------------------------------------------------
    // register word offsets
    // ----------------------------------------------------------------
    localparam logic [3:0]  OFS_CTRL        = 4'h0;
    localparam logic [3:0]  OFS_TMR_IN_LO   = 4'h1;
    localparam logic [3:0]  OFS_TMR_IN_HI   = 4'h2;
    localparam logic [3:0]  OFS_CNT_IN_LO   = 4'h3;
    localparam logic [3:0]  OFS_CNT_IN_HI   = 4'h4;
    localparam logic [3:0]  OFS_CNT_CLR     = 4'h5;
    localparam logic [3:0]  OFS_CMP         = 4'h6;
    localparam logic [3:0]  OFS_SHIFT       = 4'h7;
    localparam logic [3:0]  OFS_VIEW_SEL    = 4'h8;
    localparam logic [3:0]  OFS_VIEW        = 4'h9;
    localparam logic [3:0]  OFS_STATUS      = 4'hA;
    localparam logic [3:0]  OFS_POOL0       = 4'hB;
    localparam logic [3:0]  OFS_POOL1       = 4'hC;
    localparam logic [3:0]  OFS_POOL2       = 4'hD;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          CTRL_FAST_BIT   = 0;
    localparam int          CLR_FIRST_LSB   = 0;
    localparam int          CLR_LAST_LSB    = 8;
    localparam int          CLR_ACTIVE_BIT  = 16;
    localparam int          CLR_RANGE_BIT   = 17;
    localparam int          CMP_IDX_LSB     = 0;
    localparam int          CMP_OPND_LSB    = 16;
    localparam int          CMP_RUNG_BIT    = 31;
    localparam int          SH_START_LSB    = 0;
    localparam int          SH_LAST_LSB     = 8;
    localparam int          SH_DATA_BIT     = 16;
    localparam int          SH_CLK_BIT      = 17;
    localparam int          SH_RST_BIT      = 18;
    localparam int          VIEW_CNT_LSB    = 16;
    localparam int          ST_LESS_BIT     = 0;
    localparam int          ST_ATLEAST_BIT  = 1;
    localparam int          ST_FAST_BIT     = 2;

    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;

endpackage : plc_tcs_pkg

//--- pkg/shift_chain_if.sv
`timescale 1ns/10ps
interface shift_chain_if;
    logic [6:0]  start_idx;
    logic [6:0]  last_idx;
    logic        data_in;
    logic        step;
    logic        clear;
    logic [76:0] pool;

    modport ctrl  (output start_idx, output last_idx, output data_in, output step,
                   output clear, input pool);
    modport chain (input start_idx, input last_idx, input data_in, input step,
                   input clear, output pool);
endinterface : shift_chain_if

//--- hdl/timebase_divider.sv
`timescale 1ns/10ps
module timebase_divider
    import plc_tcs_pkg::*;
#(
    parameter int CENTI_CYC = CENTI_CYCLES
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // one-cycle time base enables
    output logic      centi_tick,
    output logic      deci_tick
);

    logic [DIV_W-1:0] div_q;
    logic [3:0]       deci_q;
    logic             wrap;

    assign wrap = (div_q == DIV_W'(CENTI_CYC - 1));

    // ----------------------------------------------------------------
    // hundredth-second divider
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_q <= '0;
        else if (wrap)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    // tenth derived from the hundredth so both bases stay in phase
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            deci_q <= '0;
        else if (wrap)
            deci_q <= (deci_q == DECI_LAST) ? 4'h0 : deci_q + 4'h1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            centi_tick <= 1'b0;
            deci_tick  <= 1'b0;
        end
        else
        begin
            centi_tick <= wrap;
            deci_tick  <= wrap && (deci_q == DECI_LAST);
        end
    end

endmodule : timebase_divider

//--- hdl/relay_bit_shift_chain.sv
`timescale 1ns/10ps
module relay_bit_shift_chain
    import plc_tcs_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // controls from the rung side
    shift_chain_if.chain sc
);

    logic [POOL_BITS-1:0] pool_q;
    logic [POOL_BITS+1:0] ext;
    logic                 ascend;
    logic                 blk_ok;
    logic [6:0]           lo;
    logic [6:0]           hi;

    assign ext     = {1'b0, pool_q, 1'b0};
    assign ascend  = (sc.start_idx <= sc.last_idx);
    assign lo      = ascend ? sc.start_idx : sc.last_idx;
    assign hi      = ascend ? sc.last_idx : sc.start_idx;
    // addresses outside the pool leave every relay alone
    assign blk_ok  = (sc.start_idx <= POOL_LAST) && (sc.last_idx <= POOL_LAST);
    assign sc.pool = pool_q;

    // ----------------------------------------------------------------
    // one flip-flop per relay of the shared pool
    // ----------------------------------------------------------------
    for (genvar i = 0; i < POOL_BITS; i++)
    begin : g_relay
        logic in_blk;
        assign in_blk = blk_ok && (7'(i) >= lo) && (7'(i) <= hi);

        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
                pool_q[i] <= 1'b0;
            else if (sc.clear && in_blk)
                pool_q[i] <= 1'b0;
            else if (sc.step && in_blk)
            begin
                if (7'(i) == sc.start_idx)
                    pool_q[i] <= sc.data_in;
                else if (ascend)
                    pool_q[i] <= ext[i];
                else
                    pool_q[i] <= ext[i+2];
            end
        end
    end

endmodule : relay_bit_shift_chain

//--- hdl/plc_timer_counter_shift_unit.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module plc_timer_counter_shift_unit
    import plc_tcs_pkg::*;
#(
    parameter int CENTI_CYC = CENTI_CYCLES
)
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // comparative contacts and mode
    output logic             LESS_CONTACT,
    output logic             AT_LEAST_CONTACT,
    output logic             FAST_MODE
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic                  fast_q;
    logic [NUM_ELEM-1:0]   tmr_in_q;
    logic [NUM_ELEM-1:0]   cnt_in_q;
    logic [NUM_ELEM-1:0]   cnt_prev_q;
    logic [NUM_ELEM-1:0]   cnt_rise;
    logic [ELEM_IDX_W-1:0] clr_first_q;
    logic [ELEM_IDX_W-1:0] clr_last_q;
    logic                  clr_active_q;
    logic                  clr_range_q;
    logic [ELEM_IDX_W-1:0] cmp_idx_q;
    logic [VALUE_W-1:0]    cmp_opnd_q;
    logic                  cmp_rung_q;
    logic [6:0]            sh_start_q;
    logic [6:0]            sh_last_q;
    logic                  sh_data_q;
    logic                  sh_clk_q;
    logic                  sh_clk_prev_q;
    logic                  sh_rst_q;
    logic [ELEM_IDX_W-1:0] view_sel_q;
    logic [VALUE_W-1:0]    timer_q [NUM_ELEM];
    logic [VALUE_W-1:0]    count_q [NUM_ELEM];
    logic                  less_q;
    logic                  at_least_q;
    logic [31:0]           rdata_q;
    logic [31:0]           rd_word;
    logic [VALUE_W-1:0]    cmp_value;
    logic                  centi_tick;
    logic                  deci_tick;
    logic                  base_tick;

    shift_chain_if sc ();

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // single form uses only the first index
    function automatic logic clr_selects(
        input logic [ELEM_IDX_W-1:0] idx,
        input logic [ELEM_IDX_W-1:0] first,
        input logic [ELEM_IDX_W-1:0] last,
        input logic                  range_mode
    );
        logic [ELEM_IDX_W-1:0] lo;
        logic [ELEM_IDX_W-1:0] hi;
        lo = (first <= last) ? first : last;
        hi = (first <= last) ? last : first;
        if (range_mode)
            clr_selects = (idx >= lo) && (idx <= hi);
        else
            clr_selects = (idx == first);
    endfunction : clr_selects

    function automatic logic [VALUE_W-1:0] saturating_inc(input logic [VALUE_W-1:0] v);
        saturating_inc = (v == VALUE_MAX) ? v : v + 1'b1;
    endfunction : saturating_inc

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    timebase_divider #(
        .CENTI_CYC  (CENTI_CYC)
    ) u_timebase (
        .clk        (MCLK),
        .rst        (RST),
        .centi_tick (centi_tick),
        .deci_tick  (deci_tick)
    );

    assign base_tick = fast_q ? centi_tick : deci_tick;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            fast_q <= 1'b0;
        else if (WR && ADDR == OFS_CTRL)
            fast_q <= WDATA[CTRL_FAST_BIT];
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            tmr_in_q <= '0;
        else if (WR && ADDR == OFS_TMR_IN_LO)
            tmr_in_q[31:0] <= WDATA;
        else if (WR && ADDR == OFS_TMR_IN_HI)
            tmr_in_q[63:32] <= WDATA;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            cnt_in_q <= '0;
        else if (WR && ADDR == OFS_CNT_IN_LO)
            cnt_in_q[31:0] <= WDATA;
        else if (WR && ADDR == OFS_CNT_IN_HI)
            cnt_in_q[63:32] <= WDATA;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            clr_first_q  <= '0;
            clr_last_q   <= '0;
            clr_active_q <= 1'b0;
            clr_range_q  <= 1'b0;
        end
        else if (WR && ADDR == OFS_CNT_CLR)
        begin
            clr_first_q  <= WDATA[CLR_FIRST_LSB +: ELEM_IDX_W];
            clr_last_q   <= WDATA[CLR_LAST_LSB +: ELEM_IDX_W];
            clr_active_q <= WDATA[CLR_ACTIVE_BIT];
            clr_range_q  <= WDATA[CLR_RANGE_BIT];
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            cmp_idx_q  <= '0;
            cmp_opnd_q <= '0;
            cmp_rung_q <= 1'b0;
        end
        else if (WR && ADDR == OFS_CMP)
        begin
            cmp_idx_q  <= WDATA[CMP_IDX_LSB +: ELEM_IDX_W];
            cmp_opnd_q <= WDATA[CMP_OPND_LSB +: VALUE_W];
            cmp_rung_q <= WDATA[CMP_RUNG_BIT];
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sh_start_q <= '0;
            sh_last_q  <= '0;
            sh_data_q  <= 1'b0;
            sh_clk_q   <= 1'b0;
            sh_rst_q   <= 1'b0;
        end
        else if (WR && ADDR == OFS_SHIFT)
        begin
            sh_start_q <= WDATA[SH_START_LSB +: POOL_IDX_W];
            sh_last_q  <= WDATA[SH_LAST_LSB +: POOL_IDX_W];
            sh_data_q  <= WDATA[SH_DATA_BIT];
            sh_clk_q   <= WDATA[SH_CLK_BIT];
            sh_rst_q   <= WDATA[SH_RST_BIT];
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            view_sel_q <= '0;
        else if (WR && ADDR == OFS_VIEW_SEL)
            view_sel_q <= WDATA[ELEM_IDX_W-1:0];
    end

    // ----------------------------------------------------------------
    // interval up timers
    // ----------------------------------------------------------------
    // a mode change mid-run keeps the value and only changes the step size
    for (genvar g = 0; g < NUM_ELEM; g++)
    begin : g_timer
        always_ff @(posedge MCLK or posedge RST)
        begin
            if (RST)
                timer_q[g] <= '0;
            else if (!tmr_in_q[g])
                timer_q[g] <= '0;
            else if (base_tick)
                timer_q[g] <= saturating_inc(timer_q[g]);
        end
    end

    // ----------------------------------------------------------------
    // edge up counters
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            cnt_prev_q <= '0;
        else
            cnt_prev_q <= cnt_in_q;
    end

    assign cnt_rise = cnt_in_q & ~cnt_prev_q;

    for (genvar g = 0; g < NUM_ELEM; g++)
    begin : g_counter
        always_ff @(posedge MCLK or posedge RST)
        begin
            if (RST)
                count_q[g] <= '0;
            else if (clr_active_q && clr_selects(ELEM_IDX_W'(g), clr_first_q,
                                                 clr_last_q, clr_range_q))
                count_q[g] <= '0;
            else if (cnt_rise[g])
                count_q[g] <= saturating_inc(count_q[g]);
        end
    end

    // ----------------------------------------------------------------
    // series comparative counter contacts
    // ----------------------------------------------------------------
    assign cmp_value = count_q[cmp_idx_q];

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            less_q     <= 1'b0;
            at_least_q <= 1'b0;
        end
        else
        begin
            less_q     <= cmp_rung_q && (cmp_value < cmp_opnd_q);
            at_least_q <= cmp_rung_q && (cmp_value >= cmp_opnd_q);
        end
    end

    assign LESS_CONTACT     = less_q;
    assign AT_LEAST_CONTACT = at_least_q;
    assign FAST_MODE        = fast_q;

    // ----------------------------------------------------------------
    // shift chain
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            sh_clk_prev_q <= 1'b0;
        else
            sh_clk_prev_q <= sh_clk_q;
    end

    assign sc.start_idx = sh_start_q;
    assign sc.last_idx  = sh_last_q;
    assign sc.data_in   = sh_data_q;
    assign sc.step      = sh_clk_q && !sh_clk_prev_q;
    assign sc.clear     = sh_rst_q;

    relay_bit_shift_chain u_shift (
        .clk (MCLK),
        .rst (RST),
        .sc  (sc.chain)
    );

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // values are visible only by reading them back, there is no done flag
    always_comb
    begin
        rd_word = RESET_WORD;
        if (ADDR == OFS_CTRL)
            rd_word[CTRL_FAST_BIT] = fast_q;
        else if (ADDR == OFS_TMR_IN_LO)
            rd_word = tmr_in_q[31:0];
        else if (ADDR == OFS_TMR_IN_HI)
            rd_word = tmr_in_q[63:32];
        else if (ADDR == OFS_CNT_IN_LO)
            rd_word = cnt_in_q[31:0];
        else if (ADDR == OFS_CNT_IN_HI)
            rd_word = cnt_in_q[63:32];
        else if (ADDR == OFS_CNT_CLR)
        begin
            rd_word[CLR_FIRST_LSB +: ELEM_IDX_W] = clr_first_q;
            rd_word[CLR_LAST_LSB +: ELEM_IDX_W]  = clr_last_q;
            rd_word[CLR_ACTIVE_BIT]              = clr_active_q;
            rd_word[CLR_RANGE_BIT]               = clr_range_q;
        end
        else if (ADDR == OFS_CMP)
        begin
            rd_word[CMP_IDX_LSB +: ELEM_IDX_W] = cmp_idx_q;
            rd_word[CMP_OPND_LSB +: VALUE_W]   = cmp_opnd_q;
            rd_word[CMP_RUNG_BIT]              = cmp_rung_q;
        end
        else if (ADDR == OFS_SHIFT)
        begin
            rd_word[SH_START_LSB +: POOL_IDX_W] = sh_start_q;
            rd_word[SH_LAST_LSB +: POOL_IDX_W]  = sh_last_q;
            rd_word[SH_DATA_BIT]                = sh_data_q;
            rd_word[SH_CLK_BIT]                 = sh_clk_q;
            rd_word[SH_RST_BIT]                 = sh_rst_q;
        end
        else if (ADDR == OFS_VIEW_SEL)
            rd_word[ELEM_IDX_W-1:0] = view_sel_q;
        else if (ADDR == OFS_VIEW)
        begin
            rd_word[VALUE_W-1:0]                = timer_q[view_sel_q];
            rd_word[VIEW_CNT_LSB +: VALUE_W]    = count_q[view_sel_q];
        end
        else if (ADDR == OFS_STATUS)
        begin
            rd_word[ST_LESS_BIT]    = less_q;
            rd_word[ST_ATLEAST_BIT] = at_least_q;
            rd_word[ST_FAST_BIT]    = fast_q;
        end
        else if (ADDR == OFS_POOL0)
            rd_word = sc.pool[31:0];
        else if (ADDR == OFS_POOL1)
            rd_word = sc.pool[63:32];
        else if (ADDR == OFS_POOL2)
            rd_word[12:0] = sc.pool[76:64];
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            rdata_q <= RESET_WORD;
        else if (RD)
            rdata_q <= rd_word;
        else
            rdata_q <= RESET_WORD;
    end

    assign RDATA = rdata_q;

endmodule : plc_timer_counter_shift_unit

//--- sim/rung_master.sv
`timescale 1ns/10ps
module rung_master
(
    // register bus
    input  wire logic        MCLK,
    input  wire logic [31:0] RDATA,
    output logic      [3:0]  ADDR,
    output logic      [31:0] WDATA,
    output logic             WR,
    output logic             RD
);
    initial {ADDR, WDATA, WR, RD} = '0;

    // two cycles per write so a strobe is never set twice in one step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge MCLK);
        WR    <= 1'b0;
        @(posedge MCLK);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge MCLK);
        RD   <= 1'b0;
        // read data stand only in this cycle; sample mid-cycle, not at the edge that drops them
        @(negedge MCLK);
        d = RDATA;
        @(posedge MCLK);
    endtask : rd
endmodule : rung_master

//--- sim/plc_tcs_sva.sv
`timescale 1ns/10ps
module plc_tcs_checker
    import plc_tcs_pkg::*;
#(
    parameter int CENTI_CYC = CENTI_CYCLES
)
(
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic [3:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        LESS_CONTACT,
    input wire logic        AT_LEAST_CONTACT,
    input wire logic        FAST_MODE
);
    logic       fast_q;
    logic [1:0] cw_q;
    wire        ctrl_wr = WR && ADDR == OFS_CTRL;
    wire        cmp_wr  = WR && ADDR == OFS_CMP;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // mode copy may lag a write by up to two edges
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            fast_q <= 1'b0;
            cw_q   <= 2'b00;
        end
        else
        begin
            cw_q <= {cw_q[0], ctrl_wr};
            if (ctrl_wr)
                fast_q <= WDATA[0];
        end
    end

    property p_idle_rdata;
        !$past(RD) |-> RDATA == 32'h0000_0000;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read slot");
    property p_unmapped;
        RD && ADDR >= 4'hE |=> RDATA == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_exclusive;
        !(LESS_CONTACT && AT_LEAST_CONTACT);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("both contacts on");
    property p_rung_off;
        cmp_wr && !WDATA[31] |=> ##1 !LESS_CONTACT && !AT_LEAST_CONTACT;
    endproperty
    a_rung_off: assert property (p_rung_off) else $error("contact on, rung off");
    property p_rung_on;
        cmp_wr && WDATA[31] |=> ##1 LESS_CONTACT != AT_LEAST_CONTACT;
    endproperty
    a_rung_on: assert property (p_rung_on) else $error("no contact with rung on");
    property p_zero_opnd;
        cmp_wr && WDATA[31] && WDATA[29:16] == 14'h0000 |=> ##1 AT_LEAST_CONTACT;
    endproperty
    a_zero_opnd: assert property (p_zero_opnd) else $error("at least zero off");
    property p_fast;
        cw_q == 2'b00 |-> FAST_MODE == fast_q;
    endproperty
    a_fast: assert property (p_fast) else $error("fast mode not written value");
    property p_status;
        RD && ADDR == OFS_STATUS |=> RDATA == {29'h0, $past(FAST_MODE),
            $past(AT_LEAST_CONTACT), $past(LESS_CONTACT)};
    endproperty
    a_status: assert property (p_status) else $error("status word wrong");
    property p_view_max;
        RD && ADDR == OFS_VIEW |=> RDATA[13:0] <= VALUE_MAX && RDATA[29:16] <= VALUE_MAX;
    endproperty
    a_view_max: assert property (p_view_max) else $error("value past max");
endmodule : plc_tcs_checker

//--- sim/test_plc_timer_counter_shift_unit.sv
`timescale 1ns/10ps
module test_plc_timer_counter_shift_unit
    import plc_tcs_pkg::*;
;
    // short hundredth so saturation fits the run
    localparam int CC = 3;
    typedef struct {logic [31:0] cmp; logic [1:0] ex;} row_s;
    logic        MCLK = 1'b0;
    logic        RST  = 1'b1;
    logic [3:0]  ADDR;
    logic [31:0] WDATA, RDATA, v;
    logic [13:0] d;
    logic        WR, RD, LESS_CONTACT, AT_LEAST_CONTACT, FAST_MODE;
    int          mismatches = 0;
    int          cmp_count  = 0;
    row_s        rows [6];

    always #25 MCLK = ~MCLK;
    rung_master rm (.MCLK(MCLK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD));
    plc_timer_counter_shift_unit #(.CENTI_CYC(CC)) DUT (.MCLK(MCLK), .RST(RST),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .LESS_CONTACT(LESS_CONTACT), .AT_LEAST_CONTACT(AT_LEAST_CONTACT),
        .FAST_MODE(FAST_MODE));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic pulse(input int b, input int n);
        repeat (n)
        begin
            rm.wr(OFS_CNT_IN_LO, 32'h1 << b);
            rm.wr(OFS_CNT_IN_LO, 32'h0);
        end
    endtask : pulse

    task automatic view(input logic [31:0] i);
        rm.wr(OFS_VIEW_SEL, i);
        rm.rd(OFS_VIEW, v);
    endtask : view

    task automatic shift(input logic [31:0] f, input logic b);
        rm.wr(OFS_SHIFT, f);
        rm.wr(OFS_SHIFT, f | {b, 16'h0} | 32'h2_0000);
    endtask : shift

    // two view reads exactly 30 cycles apart
    task automatic tstep();
        logic [13:0] a;
        rm.rd(OFS_VIEW, v);
        a = v[13:0];
        repeat (28) @(posedge MCLK);
        rm.rd(OFS_VIEW, v);
        d = v[13:0] - a;
    endtask : tstep

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        rows = '{'{32'h8005_0003, 2'b10}, '{32'h8006_0003, 2'b10}, '{32'h8007_0003, 2'b01},
                 '{32'h0000_0003, 2'b00}, '{32'hA70F_0003, 2'b01}, '{32'h8000_0003, 2'b10}};
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        check("outs", {FAST_MODE, AT_LEAST_CONTACT, LESS_CONTACT}, 32'h0);
        pulse(3, 5);
        rm.wr(OFS_CNT_IN_LO, 32'h8);
        repeat (5) @(posedge MCLK);
        rm.wr(OFS_CNT_IN_LO, 32'h0);
        view(3);
        check("cnt3", v[29:16], 32'd6);
        foreach (rows[i])
        begin
            rm.wr(OFS_CMP, rows[i].cmp);
            @(posedge MCLK);
            check("contacts", {AT_LEAST_CONTACT, LESS_CONTACT}, rows[i].ex);
        end
        $display("contact rows done");
        pulse(4, 10001);
        view(4);
        check("cnt sat", v[29:16], 32'd9999);
        pulse(5, 2);
        pulse(6, 2);
        rm.wr(OFS_CNT_CLR, 32'h0001_0605);
        rm.wr(OFS_CNT_CLR, 32'h0);
        view(5);
        check("cnt5", v[29:16], 32'd0);
        view(6);
        check("cnt6", v[29:16], 32'd2);
        rm.wr(OFS_CNT_CLR, 32'h0003_0304);
        pulse(3, 2);
        rm.wr(OFS_CNT_CLR, 32'h0);
        view(3);
        check("cnt3 clr", v[29:16], 32'd0);
        view(4);
        check("cnt4 clr", v[29:16], 32'd0);
        pulse(3, 1);
        view(3);
        check("cnt3 again", v[29:16], 32'd1);
        rm.wr(OFS_CNT_IN_HI, 32'h1);
        view(32);
        check("cnt32", v[29:16], 32'd1);
        $display("counter done");
        rm.wr(OFS_VIEW_SEL, 32'd2);
        rm.wr(OFS_TMR_IN_LO, 32'h4);
        tstep();
        check("deci step", d, 32'd1);
        rm.wr(OFS_CTRL, 32'h1);
        rm.rd(OFS_STATUS, v);
        check("fast", v[2], 32'd1);
        tstep();
        check("centi step", d, 32'd10);
        repeat (31000) @(posedge MCLK);
        tstep();
        check("tmr sat", v[13:0], 32'd9999);
        check("tmr hold", d, 32'd0);
        rm.wr(OFS_TMR_IN_LO, 32'h0);
        rm.rd(OFS_VIEW, v);
        check("tmr clr", v[13:0], 32'd0);
        $display("timer done");
        shift(32'h0700, 1'b1);
        shift(32'h0700, 1'b0);
        shift(32'h0700, 1'b1);
        rm.rd(OFS_POOL0, v);
        check("pool up", v, 32'h0000_0005);
        shift(32'h0D14, 1'b1);
        shift(32'h0D14, 1'b0);
        rm.rd(OFS_POOL0, v);
        check("pool down", v, 32'h0008_0005);
        shift(32'h4_0700, 1'b1);
        rm.rd(OFS_POOL0, v);
        check("pool rst", v, 32'h0008_0000);
        repeat (77) shift(32'h4C00, 1'b1);
        shift(32'h4D00, 1'b0);
        rm.rd(OFS_POOL0, v);
        check("pool off", v, 32'hFFFF_FFFF);
        rm.rd(OFS_POOL1, v);
        check("pool1", v, 32'hFFFF_FFFF);
        rm.rd(OFS_POOL2, v);
        check("pool2", v, 32'h0000_1FFF);
        shift(32'h4040, 1'b0);
        rm.rd(OFS_POOL2, v);
        check("pool one", v, 32'h0000_1FFE);
        rm.rd(4'hE, v);
        check("unmapped", v, 32'h0);
        $display("shift done");
        stop_test();
    end

    initial
    begin
        #(90000 * 50);
        mismatches++;
        stop_test();
    end
endmodule : test_plc_timer_counter_shift_unit

bind plc_timer_counter_shift_unit plc_tcs_checker #(.CENTI_CYC(CENTI_CYC)) chk (.MCLK(MCLK),
    .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .LESS_CONTACT(LESS_CONTACT), .AT_LEAST_CONTACT(AT_LEAST_CONTACT), .FAST_MODE(FAST_MODE));
